// file: rtl/power_ok_pkg.sv
package power_ok_pkg;

  // ---------------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------------
  localparam int unsigned NUM_BUCK = 2;
  localparam int unsigned NUM_LIN  = 2;
  localparam int unsigned NUM_RAIL = NUM_BUCK + NUM_LIN;

  // ---------------------------------------------------------------------
  // register word offsets (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [3:0] ADDR_CONFIG_A = 4'h0;
  localparam logic [3:0] ADDR_CONFIG_B = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'hc;

  // config_a fields
  localparam int unsigned CA_BUCK_SEL = 0;  // 2 bits
  localparam int unsigned CA_LIN_SEL  = 2;  // 2 bits
  localparam int unsigned CA_WINDOW   = 4;  // 4 bits, one per rail
  localparam int unsigned CA_POL      = 8;
  localparam int unsigned CA_OD       = 9;
  localparam logic [31:0] CONFIG_A_RST = 32'h0000_000f;

  // config_b fields
  localparam int unsigned CB_TWARN_SEL = 0;
  localparam int unsigned CB_MODE      = 1;  // read only, from strap
  localparam int unsigned CB_CLKDET_EN = 2;
  localparam logic [31:0] CONFIG_B_RST = 32'h0000_0000;

  // irq status fields (write 1 to clear)
  localparam int unsigned IS_FAULT   = 0;   // 4 bits, rail fault latch
  localparam int unsigned IS_TSD     = 4;
  localparam int unsigned IS_OVP     = 5;
  localparam int unsigned IS_RESET   = 6;
  localparam int unsigned IS_CLKDET  = 7;
  localparam int unsigned IS_PWROK   = 8;
  localparam int unsigned IS_OK_STAT = 16;  // live status, read only
  localparam int unsigned IS_TW_STAT = 17;
  localparam int unsigned IRQ_BITS   = 9;
  localparam logic [8:0] IRQ_MASK_RST = 9'h000;
  localparam logic [8:0] IRQ_STAT_RST = 9'h040;  // reset indication set
  localparam logic [8:0] UNMASKABLE   = 9'h030;

  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned GATE_US     = 800;
  localparam int unsigned GATE_CYCLES = GATE_US * (CLK_HZ / 1_000_000);

  typedef struct packed {
    logic [NUM_RAIL-1:0] enabled;
    logic [NUM_RAIL-1:0] under_ok;
    logic [NUM_RAIL-1:0] over_ok;
    logic [NUM_RAIL-1:0] changing;
  } rail_state_t;

  typedef struct packed {
    logic thermal_warn;
    logic thermal_sd;
    logic input_ov;
    logic sync_clk_ok;
  } hazard_t;

  typedef enum logic [1:0] {
    GATE_IDLE = 2'b00,
    GATE_HOLD = 2'b01,
    GATE_DONE = 2'b11
  } gate_state_t;

endpackage

// file: rtl/power_good_fault_monitor.sv
// The Wishbone register port and the register offsets are this design's own decisions.
module power_good_fault_monitor
  import power_ok_pkg::*;
#(
  parameter int unsigned GATE_COUNT = GATE_CYCLES
) (
  // clock and reset
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // analog monitor side
  input  wire rail_state_t rails_i,
  input  wire hazard_t     hazard_i,
  input  wire logic        power_ok_mode_select_i,
  // outputs
  output logic             power_ok_pin_o,
  output logic             power_ok_pin_oe_o,
  output logic             irq_out_n_o,
  output logic             rail_kill_o,
  output logic             general_out_1_o,
  output logic             general_out_2_o
);

  // ---------------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  // removal is retimed to the clock; assertion still acts at once
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // ---------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------
  logic [31:0]         config_a_reg;
  logic [31:0]         config_b_reg;
  logic [IRQ_BITS-1:0] irq_stat_reg;
  logic [IRQ_BITS-1:0] irq_stat_next;
  logic [IRQ_BITS-1:0] irq_mask_reg;
  logic                mode_reg;
  logic                mode_loaded_reg;
  logic                ack_reg;
  logic [31:0]         rdata_reg;
  logic                ok_reg;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic addr_hit(input logic [3:0] adr,
                                    input logic [3:0] offset);
    return adr == offset;
  endfunction

  // one decode per word, shared by the write strobes and the read mux
  wire         hit_ca  = addr_hit(wb_adr_i, ADDR_CONFIG_A);
  wire         hit_cb  = addr_hit(wb_adr_i, ADDR_CONFIG_B);
  wire         hit_is  = addr_hit(wb_adr_i, ADDR_IRQ_STAT);
  wire         hit_im  = addr_hit(wb_adr_i, ADDR_IRQ_MASK);

  // a request is taken only while ack is low, so each cycle acts once
  wire         req     = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire         wr      = req & wb_we_i;
  wire         rd_req  = req & ~wb_we_i;
  wire         wr_ca   = wr & hit_ca;
  wire         wr_cb   = wr & hit_cb;
  wire         wr_is   = wr & hit_is;
  wire         wr_im   = wr & hit_im;
  wire [31:0]  w1c     = merge(32'h0, wb_dat_i, wb_sel_i);
  wire [31:0]  mask_w  = merge({23'h0, irq_mask_reg}, wb_dat_i, wb_sel_i);

  // ---------------------------------------------------------------------
  // fields
  // ---------------------------------------------------------------------
  wire [NUM_BUCK-1:0] buck_rail_monitor_select =
    config_a_reg[CA_BUCK_SEL +: NUM_BUCK];
  wire [NUM_LIN-1:0]  linear_rail_monitor_select =
    config_a_reg[CA_LIN_SEL +: NUM_LIN];
  wire [NUM_RAIL-1:0] rail_window_select = config_a_reg[CA_WINDOW +: NUM_RAIL];
  wire power_ok_polarity    = config_a_reg[CA_POL];
  wire power_ok_open_drain  = config_a_reg[CA_OD];
  wire thermal_warn_monitor_select = config_b_reg[CB_TWARN_SEL];
  wire clkdet_en            = config_b_reg[CB_CLKDET_EN];

  // ---------------------------------------------------------------------
  // power ok combine
  // ---------------------------------------------------------------------
  wire [NUM_RAIL-1:0] rail_sel =
    {linear_rail_monitor_select, buck_rail_monitor_select};
  // window bit picks undervoltage only or both limits
  wire [NUM_RAIL-1:0] rail_valid =
    rails_i.under_ok & (rails_i.over_ok | ~rail_window_select);
  // disabled rails are masked out; current limit is not an input at all
  wire [NUM_RAIL-1:0] rail_bad =
    rail_sel & rails_i.enabled & ~rail_valid;
  wire thermal_warn_status = hazard_i.thermal_warn;
  wire hazard_bad =
    (thermal_warn_monitor_select & thermal_warn_status) |
    irq_stat_reg[IS_OVP] | irq_stat_reg[IS_TSD];
  wire live_ok = ~(|rail_bad) & ~hazard_bad;

  // ---------------------------------------------------------------------
  // gating timer
  // ---------------------------------------------------------------------
  gate_state_t        gate_reg;
  gate_state_t        gate_next;
  logic [15:0]        gate_cnt_reg;
  logic [NUM_RAIL-1:0] en_prev_reg;
  wire gated_mode = mode_loaded_reg & ~mode_reg;
  wire rail_event = (|(rails_i.enabled & ~en_prev_reg)) |
                    (|(rails_i.changing & rails_i.enabled));
  wire gate_expired = (gate_cnt_reg == 16'(GATE_COUNT - 1));

  always_comb begin
    gate_next = gate_reg;
    case (gate_reg)
      GATE_IDLE: if (rail_event) gate_next = GATE_HOLD;
      GATE_HOLD: if (gate_expired && !rail_event) gate_next = GATE_DONE;
      GATE_DONE: if (rail_event) gate_next = GATE_HOLD;
      default:   gate_next = GATE_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      gate_reg    <= GATE_IDLE;
      en_prev_reg <= '0;
    end else begin
      gate_reg    <= gate_next;
      en_prev_reg <= rails_i.enabled;
    end
  end

  // the count restarts on every event, so back-to-back changes stretch it
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      gate_cnt_reg <= 16'h0000;
    end else if (rail_event || gate_reg != GATE_HOLD) begin
      gate_cnt_reg <= 16'h0000;
    end else if (!gate_expired) begin
      gate_cnt_reg <= gate_cnt_reg + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------
  // power ok state
  // ---------------------------------------------------------------------
  // rail faults are frozen while the gate holds; hazards always pass.
  // the event cycle is held too: an enable that comes with a low rail
  // would otherwise slip through before the state machine reaches hold
  wire holding  = gated_mode & (rail_event | (gate_reg == GATE_HOLD));
  wire ok_next  = holding ? (ok_reg & ~hazard_bad) : live_ok;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ok_reg <= 1'b1;
    end else begin
      ok_reg <= ok_next;
    end
  end

  // ---------------------------------------------------------------------
  // interrupt status
  // ---------------------------------------------------------------------
  logic ok_prev_reg;
  wire                ok_fell_set = ok_prev_reg & ~ok_reg;
  wire                clkdet_set  = clkdet_en & ~hazard_i.sync_clk_ok;
  wire                ovp_set     = hazard_i.input_ov;
  wire                tsd_set     = hazard_i.thermal_sd;
  // no rail fault is latched while the gate hides it
  wire [NUM_RAIL-1:0] fault_set   = holding ? 4'h0 : rail_bad;
  wire [IRQ_BITS-1:0] irq_set = {
    ok_fell_set,
    clkdet_set,
    1'b0,
    ovp_set,
    tsd_set,
    fault_set
  };
  wire [IRQ_BITS-1:0] irq_clr = wr_is ? w1c[IRQ_BITS-1:0] : '0;
  // set wins over a simultaneous write-1 clear
  assign irq_stat_next = irq_set | (irq_stat_reg & ~irq_clr);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= IRQ_STAT_RST;
    end else begin
      irq_stat_reg <= irq_stat_next;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ok_prev_reg <= 1'b1;
    end else begin
      ok_prev_reg <= ok_reg;
    end
  end

  // ---------------------------------------------------------------------
  // interrupt output and shutdown
  // ---------------------------------------------------------------------
  wire irq_any = |(irq_stat_reg & (~irq_mask_reg | UNMASKABLE));
  wire shutdown = irq_stat_reg[IS_TSD] | irq_stat_reg[IS_OVP];

  // ---------------------------------------------------------------------
  // config registers and strap capture
  // ---------------------------------------------------------------------
  // the strap is taken once, so a pin that moves later changes nothing
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg        <= 1'b0;
      mode_loaded_reg <= 1'b0;
    end else if (!mode_loaded_reg) begin
      mode_reg        <= power_ok_mode_select_i;
      mode_loaded_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      config_a_reg <= CONFIG_A_RST;
      config_b_reg <= CONFIG_B_RST;
    end else begin
      if (wr_ca) config_a_reg <= merge(config_a_reg, wb_dat_i, wb_sel_i);
      if (wr_cb) config_b_reg <= merge(config_b_reg, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_reg <= IRQ_MASK_RST;
    end else if (wr_im) begin
      irq_mask_reg <= mask_w[IRQ_BITS-1:0];
    end
  end

  // ---------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------
  wire [31:0] rd_ca = {22'h0, config_a_reg[9:0]};
  wire [31:0] rd_cb = {29'h0, config_b_reg[CB_CLKDET_EN], mode_reg,
                       config_b_reg[CB_TWARN_SEL]};
  wire [31:0] rd_is = {14'h0, thermal_warn_status, ok_reg,
                       7'h0, irq_stat_reg};
  wire [31:0] rd_im = {23'h0, irq_mask_reg};
  wire [31:0] rd_mux =
    hit_ca ? rd_ca :
    hit_cb ? rd_cb :
    hit_is ? rd_is :
    hit_im ? rd_im : 32'h0000_0000;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // read data stands until the next read, so a slow host still sees it
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_req) begin
      rdata_reg <= rd_mux;
    end
  end

  // ---------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------
  logic pin_level_reg;
  logic kill_reg;

  // registered so the pin never glitches while its sources settle
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_level_reg <= 1'b1;
    end else begin
      pin_level_reg <= ok_next ^ power_ok_polarity;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      kill_reg <= 1'b0;
    end else begin
      kill_reg <= irq_stat_next[IS_TSD] | irq_stat_next[IS_OVP];
    end
  end

  assign wb_ack_o          = ack_reg;
  assign wb_dat_o          = rdata_reg;
  assign power_ok_pin_o    = power_ok_open_drain ? 1'b0 : pin_level_reg;
  assign power_ok_pin_oe_o = ~power_ok_open_drain | ~pin_level_reg;
  assign irq_out_n_o       = ~irq_any;
  assign rail_kill_o       = kill_reg | shutdown;
  // both general outputs stay low for as long as a shutdown is pending
  assign general_out_1_o   = ~(kill_reg | shutdown);
  assign general_out_2_o   = ~(kill_reg | shutdown);

endmodule

// file: tb/power_ok_checker.sv
module power_ok_checker
  import power_ok_pkg::*;
(
  input wire logic    clock_i,
  input wire logic    resetn_i,
  input wire logic    wb_cyc_i,
  input wire logic    wb_stb_i,
  input wire logic    wb_we_i,
  input wire logic    wb_ack_o,
  input wire hazard_t hazard_i,
  input wire logic    irq_out_n_o,
  input wire logic    rail_kill_o,
  input wire logic    general_out_1_o,
  input wire logic    general_out_2_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  ack_in_one_a: assert property (req_s |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  kill_cause_a: assert property ((hazard_i.thermal_sd || hazard_i.input_ov)
    |=> rail_kill_o) else $error("rails not killed");
  kill_gpo_a: assert property (rail_kill_o |-> !general_out_1_o
    && !general_out_2_o) else $error("outputs not low");
  gpo_idle_a: assert property (!rail_kill_o |-> general_out_1_o
    && general_out_2_o) else $error("outputs low");
  kill_irq_a: assert property (rail_kill_o |-> !irq_out_n_o)
    else $error("irq not pulled");
  kill_clear_a: assert property ($fell(rail_kill_o)
    |-> wb_ack_o && wb_we_i) else $error("kill fell alone");
endmodule

bind power_good_fault_monitor power_ok_checker power_ok_checker_i (
  .clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
  .hazard_i(hazard_i), .irq_out_n_o(irq_out_n_o),
  .rail_kill_o(rail_kill_o), .general_out_1_o(general_out_1_o),
  .general_out_2_o(general_out_2_o));

// file: tb/power_ok_host.sv
module power_ok_host (
  input  wire logic pin_i,
  input  wire logic oe_i,
  output wire logic wire_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // the host reset input has a pull-up: an idle open-drain line reads 1
  assign wire_o = oe_i ? pin_i : 1'b1;
endmodule

// file: tb/testbench.sv
module testbench;
  import power_ok_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, resetn_i = 0, cyc = 0, stb = 0, we = 0, mode = 1;
  logic [3:0] adr = 4'h0;
  logic [31:0] dat = 32'h0, rd;
  wire logic [31:0] dat_o;
  wire logic ack, pin, oe, irq_n, kill, g1, g2, ok_w;
  rail_state_t rails = '{4'hf, 4'hf, 4'hf, 4'h0}, rs;
  hazard_t hz = '{1'b0, 1'b0, 1'b0, 1'b1}, hs;
  int miscompares = 0, cmp_count = 0;
  always #25 clock_i = ~clock_i;
  power_good_fault_monitor #(.GATE_COUNT(20)) power_good_fault_monitor_i (
    .clock_i(clock_i), .resetn_i(resetn_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .rails_i(rails),
    .hazard_i(hz), .power_ok_mode_select_i(mode), .power_ok_pin_o(pin),
    .power_ok_pin_oe_o(oe), .irq_out_n_o(irq_n), .rail_kill_o(kill),
    .general_out_1_o(g1), .general_out_2_o(g2));
  power_ok_host power_ok_host_i (.pin_i(pin), .oe_i(oe), .wire_o(ok_w));
  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task wait_n(input int k);
    repeat (k) @(posedge clock_i);
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(posedge clock_i);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) chk("ack", 32'h1, 32'h0);
  endtask
  task rchk(input string s, input logic [3:0] a, input logic [31:0] m,
            input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(s, e, rd & m);
  endtask
  task apply;
    @(posedge clock_i);
    rails <= rs;
    hz <= hs;
    wait_n(3);
  endtask
  task pin_chk(input logic e);
    wait_n(3);
    chk("pin", {31'h0, e}, {31'h0, ok_w});
  endtask
  task base;
    rs = '{4'hf, 4'hf, 4'hf, 4'h0};
    hs = '{1'b0, 1'b0, 1'b0, 1'b1};
    apply();
    bus(1'b1, ADDR_CONFIG_A, CONFIG_A_RST);
    bus(1'b1, ADDR_CONFIG_B, 32'h0);
    bus(1'b1, ADDR_IRQ_MASK, 32'h0);
    bus(1'b1, ADDR_IRQ_STAT, 32'h1ff);
  endtask
  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task t_regs(input logic m);
    @(posedge clock_i);
    resetn_i <= 1'b0;
    mode <= m;
    wait_n(10);
    resetn_i <= 1'b1;
    wait_n(3);
    rchk("cfg_a", ADDR_CONFIG_A, 32'hffffffff, CONFIG_A_RST);
    rchk("cfg_b", ADDR_CONFIG_B, 32'hffffffff, {30'h0, m, 1'b0});
    rchk("unmapped", 4'h2, 32'hffffffff, 32'h0);
    chk("irq_n", 32'h0, {31'h0, irq_n});
    bus(1'b1, ADDR_IRQ_STAT, 32'h0);
    rchk("reset_bit", ADDR_IRQ_STAT, 32'h40, 32'h40);
    bus(1'b1, ADDR_IRQ_STAT, 32'h40);
    rchk("cleared", ADDR_IRQ_STAT, 32'h1ff, 32'h0);
    chk("irq_n", 32'h1, {31'h0, irq_n});
  endtask
  task t_fault;
    rs.under_ok[0] = 1'b0;
    apply();
    pin_chk(1'b0);
    rchk("fault", ADDR_IRQ_STAT, 32'h10101, 32'h00101);
    chk("irq_n", 32'h0, {31'h0, irq_n});
    bus(1'b1, ADDR_IRQ_STAT, 32'h1);
    rchk("reset_again", ADDR_IRQ_STAT, 32'h1, 32'h1);
    rs.under_ok[0] = 1'b1;
    apply();
    pin_chk(1'b1);
    rchk("latched", ADDR_IRQ_STAT, 32'h10001, 32'h10001);
    bus(1'b1, ADDR_IRQ_STAT, 32'h1ff);
    rchk("fault_clr", ADDR_IRQ_STAT, 32'h1ff, 32'h0);
  endtask
  task t_select;
    rs.over_ok[1] = 1'b0;
    apply();
    pin_chk(1'b1);
    bus(1'b1, ADDR_CONFIG_A, 32'h2f);
    pin_chk(1'b0);
    rs.over_ok[1] = 1'b1;
    rs.under_ok[0] = 1'b0;
    bus(1'b1, ADDR_CONFIG_A, 32'h0e);
    apply();
    pin_chk(1'b1);
    rs.enabled[2] = 1'b0;
    rs.under_ok[2] = 1'b0;
    apply();
    pin_chk(1'b1);
  endtask
  task t_pin;
    bus(1'b1, ADDR_CONFIG_A, 32'h10f);
    pin_chk(1'b0);
    rchk("stat_pol", ADDR_IRQ_STAT, 32'h10100, 32'h10000);
    bus(1'b1, ADDR_CONFIG_A, 32'h20f);
    pin_chk(1'b1);
    chk("oe_idle", 32'h0, {31'h0, oe});
    rs.under_ok[3] = 1'b0;
    apply();
    pin_chk(1'b0);
    chk("oe_drive", 32'h1, {31'h0, oe});
  endtask
  task t_warn;
    hs.thermal_warn = 1'b1;
    apply();
    pin_chk(1'b1);
    rchk("warn_stat", ADDR_IRQ_STAT, 32'h20000, 32'h20000);
    bus(1'b1, ADDR_CONFIG_B, 32'h1);
    pin_chk(1'b0);
  endtask
  task t_hazard(input logic ov);
    hs.input_ov = ov;
    hs.thermal_sd = !ov;
    apply();
    bus(1'b1, ADDR_IRQ_MASK, 32'h1ff);
    chk("kill", 32'h1, {31'h0, kill});
    chk("gpo", 32'h0, {30'h0, g1, g2});
    chk("irq_n", 32'h0, {31'h0, irq_n});
    hs.input_ov = 1'b0;
    hs.thermal_sd = 1'b0;
    apply();
    pin_chk(1'b0);
    bus(1'b1, ADDR_IRQ_STAT, 32'h30);
    pin_chk(1'b1);
    chk("gpo_back", 32'h3, {30'h0, g1, g2});
  endtask
  task t_clk;
    hs.sync_clk_ok = 1'b0;
    apply();
    rchk("det_off", ADDR_IRQ_STAT, 32'h80, 32'h0);
    bus(1'b1, ADDR_CONFIG_B, 32'h4);
    wait_n(3);
    rchk("det_on", ADDR_IRQ_STAT, 32'h80, 32'h80);
    bus(1'b1, ADDR_IRQ_MASK, 32'h180);
    bus(1'b1, ADDR_IRQ_STAT, 32'h1ff);
    wait_n(3);
    chk("irq_masked", 32'h1, {31'h0, irq_n});
  endtask
  task t_gate;
    rs.changing[0] = 1'b1;
    rs.under_ok[0] = 1'b0;
    apply();
    pin_chk(1'b1);
    rchk("gate_hold", ADDR_IRQ_STAT, 32'h1010f, 32'h10000);
    rs.changing[0] = 1'b0;
    apply();
    pin_chk(1'b1);
    wait_n(20);
    pin_chk(1'b0);
    rchk("gate_end", ADDR_IRQ_STAT, 32'h1000f, 32'h00001);
    rs.under_ok[0] = 1'b1;
    apply();
    pin_chk(1'b1);
    bus(1'b1, ADDR_IRQ_STAT, 32'h1ff);
  endtask
  initial begin
    rs = rails;
    hs = hz;
    t_regs(1'b1);
    t_fault();
    base();
    t_select();
    base();
    t_pin();
    base();
    t_warn();
    base();
    t_hazard(1'b1);
    base();
    t_hazard(1'b0);
    base();
    t_clk();
    base();
    t_regs(1'b0);
    t_gate();
    report_and_stop();
  end
  initial begin
    wait_n(20000);
    miscompares++;
    report_and_stop();
  end
endmodule
